// *** sdfp_port_fsm.sv ***
/*
 * data frame transmit path, descriptor interrupt chain and receive entry
 * check of one serial ata port, with a wishbone register file.
 * assumes memory fetch, link layer and adjacent port logic share the clock.
 */
// The implementer's own choices: the register offsets and the Wishbone slave port.
`default_nettype none
// Summary of operation
// - send frame data until remaining count is exhausted or 8KB went out.
// - entry with interrupt bit, acknowledged by R_OK, sets pending flag.
// - end frame on all bytes, descriptor table end or 8KB payload.
// - a DMAT from the device is ignored; sending continues.
// - good frame lowers remaining count by its size; byte count add offered.
// - after update go to interrupt, PIO update, switching idle or idle.
// - interrupt due sets descriptor processed status and clears pending flag.
// - with interrupt enable set the global bit, else branch by priority.
// - set global port bit; interrupt only with global enable set.
// - interrupt stays until software clears it; the chain goes on by priority at once.
// - received frame loads current port and clears its pending flag.
// - port with no outstanding commands gives invalid port error.
module sdfp_port_fsm #(
	parameter int NP = 16, // multiplier ports
	parameter int PW = 4, // port index width
	parameter int CW = 32 // transfer count width
) (
	input wire logic clock, // 100 MHz
	input wire logic srst, // sync reset, high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // ack
	output logic irq, // level interrupt
	input wire logic xfer_load, // load count of a port
	input wire logic [PW-1:0] xfer_port, // port to load
	input wire logic [CW-1:0] xfer_count, // transfer count in bytes
	input wire logic xfer_pio, // transfer is programmed io
	input wire logic tx_start, // begin a data frame
	input wire logic [PW-1:0] tx_port, // port of the frame
	input wire logic mem_valid, // fetched dword valid
	input wire logic [31:0] mem_data, // fetched dword
	input wire logic mem_table_end, // dword ends the descriptor table
	input wire logic mem_entry_end, // dword ends a descriptor entry
	input wire logic mem_entry_irq, // that entry has its interrupt bit
	output logic mem_ready, // dword taken
	output logic link_valid, // dword to link
	output logic [31:0] link_data, // dword to link
	output logic link_last, // dword ends the frame
	input wire logic link_ready, // link took the dword
	input wire logic link_done, // frame outcome pulse
	input wire logic link_rok, // device answered R_OK
	input wire logic link_rerr, // device answered R_ERR
	input wire logic link_sync_esc, // device sent sync escape
	input wire logic link_dmat, // device sent DMAT
	input wire logic rx_fis, // data frame arrived
	input wire logic [PW-1:0] rx_port, // its port multiplier field
	input wire logic [NP-1:0] port_outstanding, // ports with commands
	output logic byte_count_valid, // add to descriptor byte count
	output logic [sdfp_pkg::FRAME_BW-1:0] byte_count_add, // bytes to add
	output logic exit_valid, // hand-off pulse
	output logic [2:0] exit_code, // where control goes
	output logic [PW-1:0] current_port // current multiplier port
);
	localparam int FRAME_BW = sdfp_pkg::FRAME_BW;

	sdfp_pkg::sdfp_state_t state_ff, nxt_state;
	logic [PW-1:0] port_ff, nxt_port;
	logic [CW-1:0] remain_ff [NP], nxt_remain [NP];
	logic [NP-1:0] pend_ff, nxt_pend, pio_ff, nxt_pio;
	logic [FRAME_BW-1:0] fbytes_ff, nxt_fbytes;
	logic frame_irq_ff, nxt_frame_irq;
	logic mem_ready_ff, nxt_mem_ready;
	logic link_valid_ff, nxt_link_valid, link_last_ff, nxt_link_last;
	logic [31:0] link_data_ff, nxt_link_data;
	logic bc_valid_ff, nxt_bc_valid;
	logic [FRAME_BW-1:0] bc_add_ff, nxt_bc_add;
	logic exit_valid_ff, nxt_exit_valid;
	logic [2:0] exit_code_ff, nxt_exit_code;
	logic [sdfp_pkg::ST_W-1:0] st_set;
	logic gp_set;
	logic [FRAME_BW-1:0] nbytes;
	logic frame_end;

	// bus side registers
	logic [1:0] ctrl_ff, nxt_ctrl;
	logic [sdfp_pkg::ST_W-1:0] status_ff, nxt_status, mask_ff, nxt_mask;
	logic gpend_ff, nxt_gpend, irq_ff, nxt_irq;
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic sw_en, gie, wr_lane0;

	assign sw_en = ctrl_ff[sdfp_pkg::CTRL_SWITCH_BIT];
	assign gie = ctrl_ff[sdfp_pkg::CTRL_GIE_BIT];

	// pio update, then switching idle, then port idle
	function automatic logic [2:0] after_code(input logic pio,
		input logic sw);
		if (pio) begin
			return sdfp_pkg::EXIT_PIO_UPDATE;
		end else if (sw) begin
			return sdfp_pkg::EXIT_SWITCH_IDLE;
		end
		return sdfp_pkg::EXIT_PORT_IDLE;
	endfunction : after_code

	always_comb begin
		nxt_state = state_ff;
		nxt_port = port_ff;
		nxt_remain = remain_ff;
		nxt_pend = pend_ff;
		nxt_pio = pio_ff;
		nxt_fbytes = fbytes_ff;
		nxt_frame_irq = frame_irq_ff;
		nxt_mem_ready = mem_ready_ff;
		nxt_link_valid = link_valid_ff;
		nxt_link_last = link_last_ff;
		nxt_link_data = link_data_ff;
		nxt_bc_valid = 1'b0;
		nxt_bc_add = bc_add_ff;
		nxt_exit_valid = 1'b0;
		nxt_exit_code = exit_code_ff;
		st_set = '0;
		gp_set = 1'b0;
		nbytes = fbytes_ff + sdfp_pkg::DWORD_BYTES;
		frame_end = 1'b0;
		if (xfer_load) begin
			nxt_remain[xfer_port] = xfer_count;
			nxt_pio[xfer_port] = xfer_pio;
		end
		case (state_ff)
		sdfp_pkg::ST_IDLE: begin
			if (tx_start) begin
				nxt_port = tx_port;
				nxt_fbytes = '0;
				nxt_frame_irq = 1'b0;
				nxt_mem_ready = 1'b1;
				nxt_state = sdfp_pkg::ST_XMIT;
			end else if (rx_fis) begin
				nxt_port = rx_port;
				nxt_pend[rx_port] = 1'b0;
				nxt_state = sdfp_pkg::ST_RX_ENTRY;
			end
		end
		sdfp_pkg::ST_XMIT: begin
			// dmat is never read here, so a pause cannot cut the frame
			if (link_valid_ff && link_ready) begin
				nxt_link_valid = 1'b0;
				nxt_mem_ready = !link_last_ff;
				if (link_last_ff) begin
					nxt_state = sdfp_pkg::ST_WAIT;
				end
			end
			if (mem_ready_ff && mem_valid) begin
				frame_end = ({{(CW-FRAME_BW){1'b0}}, nbytes} >=
					remain_ff[port_ff]) || mem_table_end ||
					(nbytes == sdfp_pkg::FRAME_MAX_BYTES);
				nxt_fbytes = nbytes;
				nxt_link_data = mem_data;
				nxt_link_valid = 1'b1;
				nxt_link_last = frame_end;
				nxt_mem_ready = 1'b0;
				if (mem_entry_end && mem_entry_irq) begin
					nxt_frame_irq = 1'b1;
				end
			end
		end
		sdfp_pkg::ST_WAIT: begin
			if (link_done) begin
				nxt_exit_valid = 1'b1;
				if (link_sync_esc) begin
					nxt_exit_code = sdfp_pkg::EXIT_SYNC_ESCAPE;
					st_set[sdfp_pkg::ST_SYNC_BIT] = 1'b1;
					nxt_state = sdfp_pkg::ST_IDLE;
				end else if (link_rok) begin
					nxt_exit_valid = 1'b0;
					nxt_state = sdfp_pkg::ST_UPD_COUNT;
				end else if (link_rerr && sw_en) begin
					nxt_exit_code = sdfp_pkg::EXIT_NONFATAL;
					st_set[sdfp_pkg::ST_NONFATAL_BIT] = 1'b1;
					nxt_state = sdfp_pkg::ST_IDLE;
				end else begin
					nxt_exit_code = sdfp_pkg::EXIT_FATAL;
					st_set[sdfp_pkg::ST_FATAL_BIT] = 1'b1;
					nxt_state = sdfp_pkg::ST_IDLE;
				end
			end
		end
		sdfp_pkg::ST_UPD_COUNT: begin
			nxt_remain[port_ff] = remain_ff[port_ff] -
				{{(CW-FRAME_BW){1'b0}}, fbytes_ff};
			nxt_bc_valid = 1'b1;
			nxt_bc_add = fbytes_ff;
			if (frame_irq_ff || pend_ff[port_ff]) begin
				nxt_pend[port_ff] = 1'b1;
				nxt_state = sdfp_pkg::ST_DESC_SET_INTR;
			end else begin
				nxt_exit_valid = 1'b1;
				nxt_exit_code = after_code(pio_ff[port_ff], sw_en);
				nxt_state = sdfp_pkg::ST_IDLE;
			end
		end
		sdfp_pkg::ST_DESC_SET_INTR: begin
			st_set[sdfp_pkg::ST_DESC_BIT] = 1'b1;
			nxt_pend[port_ff] = 1'b0;
			if (mask_ff[sdfp_pkg::ST_DESC_BIT]) begin
				nxt_state = sdfp_pkg::ST_DESC_SET_GLOBAL;
			end else begin
				nxt_exit_valid = 1'b1;
				nxt_exit_code = after_code(pio_ff[port_ff], sw_en);
				nxt_state = sdfp_pkg::ST_IDLE;
			end
		end
		sdfp_pkg::ST_DESC_SET_GLOBAL: begin
			gp_set = 1'b1;
			if (gie) begin
				nxt_state = sdfp_pkg::ST_DESC_GEN_INTR;
			end else begin
				nxt_exit_valid = 1'b1;
				nxt_exit_code = after_code(pio_ff[port_ff], sw_en);
				nxt_state = sdfp_pkg::ST_IDLE;
			end
		end
		sdfp_pkg::ST_DESC_GEN_INTR: begin
			nxt_exit_valid = 1'b1;
			nxt_exit_code = after_code(pio_ff[port_ff], sw_en);
			nxt_state = sdfp_pkg::ST_IDLE;
		end
		sdfp_pkg::ST_RX_ENTRY: begin
			nxt_exit_valid = 1'b1;
			nxt_state = sdfp_pkg::ST_IDLE;
			if (!port_outstanding[port_ff]) begin
				nxt_exit_code = sdfp_pkg::EXIT_INVALID_PORT;
				st_set[sdfp_pkg::ST_BADPORT_BIT] = 1'b1;
			end else begin
				nxt_exit_code = sdfp_pkg::EXIT_RX_RECEIVE;
			end
		end
		default: begin
			nxt_state = sdfp_pkg::ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff <= sdfp_pkg::ST_IDLE;
			port_ff <= '0;
			remain_ff <= '{default: '0};
			pend_ff <= '0;
			pio_ff <= '0;
			fbytes_ff <= '0;
			frame_irq_ff <= 1'b0;
			mem_ready_ff <= 1'b0;
			link_valid_ff <= 1'b0;
			link_last_ff <= 1'b0;
			link_data_ff <= '0;
			bc_valid_ff <= 1'b0;
			bc_add_ff <= '0;
			exit_valid_ff <= 1'b0;
			exit_code_ff <= sdfp_pkg::EXIT_PORT_IDLE;
		end else begin
			state_ff <= nxt_state;
			port_ff <= nxt_port;
			remain_ff <= nxt_remain;
			pend_ff <= nxt_pend;
			pio_ff <= nxt_pio;
			fbytes_ff <= nxt_fbytes;
			frame_irq_ff <= nxt_frame_irq;
			mem_ready_ff <= nxt_mem_ready;
			link_valid_ff <= nxt_link_valid;
			link_last_ff <= nxt_link_last;
			link_data_ff <= nxt_link_data;
			bc_valid_ff <= nxt_bc_valid;
			bc_add_ff <= nxt_bc_add;
			exit_valid_ff <= nxt_exit_valid;
			exit_code_ff <= nxt_exit_code;
		end
	end

	// registers; a write lands on the ack edge, so set beats clear there
	assign wr_lane0 = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_mask = mask_ff;
		nxt_status = status_ff | st_set;
		nxt_gpend = gpend_ff | gp_set;
		nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
		nxt_rdata = rdata_ff;
		if (wr_lane0) begin
			case (wb_adr_i)
			sdfp_pkg::CTRL_OFS: nxt_ctrl = wb_dat_i[1:0];
			sdfp_pkg::MASK_OFS: nxt_mask = wb_dat_i[sdfp_pkg::ST_W-1:0];
			sdfp_pkg::STATUS_OFS: begin
				nxt_status = (status_ff & ~wb_dat_i[sdfp_pkg::ST_W-1:0]) |
					st_set;
			end
			sdfp_pkg::GSTAT_OFS: nxt_gpend = (gpend_ff & ~wb_dat_i[0]) | gp_set;
			default: begin
			end
			endcase
		end
		if (wb_cyc_i && wb_stb_i && !ack_ff) begin
			case (wb_adr_i)
			sdfp_pkg::CTRL_OFS: nxt_rdata = {30'h0, ctrl_ff};
			sdfp_pkg::STATUS_OFS: nxt_rdata = {27'h0, status_ff};
			sdfp_pkg::MASK_OFS: nxt_rdata = {27'h0, mask_ff};
			sdfp_pkg::GSTAT_OFS: nxt_rdata = {31'h0, gpend_ff};
			sdfp_pkg::PORT_OFS: nxt_rdata = {{(32-PW){1'b0}}, port_ff};
			sdfp_pkg::REMAIN_OFS: nxt_rdata = 32'(remain_ff[port_ff]);
			default: nxt_rdata = 32'h0;
			endcase
		end
		// level until software clears the sticky bits
		nxt_irq = gie && (nxt_gpend ||
			|(nxt_status & nxt_mask & 5'h1e));
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_ff <= sdfp_pkg::CTRL_RESET;
			status_ff <= sdfp_pkg::ST_RESET;
			mask_ff <= sdfp_pkg::MASK_RESET;
			gpend_ff <= 1'b0;
			irq_ff <= 1'b0;
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			gpend_ff <= nxt_gpend;
			irq_ff <= nxt_irq;
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	assign wb_dat_o = rdata_ff;
	assign wb_ack_o = ack_ff;
	assign irq = irq_ff;
	assign mem_ready = mem_ready_ff;
	assign link_valid = link_valid_ff;
	assign link_data = link_data_ff;
	assign link_last = link_last_ff;
	assign byte_count_valid = bc_valid_ff;
	assign byte_count_add = bc_add_ff;
	assign exit_valid = exit_valid_ff;
	assign exit_code = exit_code_ff;
	assign current_port = port_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	a_frame_cap: assert property (
		link_valid_ff |-> fbytes_ff <= sdfp_pkg::FRAME_MAX_BYTES)
		else $error("frame payload above limit");
	a_frame_end_max: assert property (
		state_ff == sdfp_pkg::ST_XMIT && mem_ready_ff && mem_valid &&
		nbytes == sdfp_pkg::FRAME_MAX_BYTES |=> link_last_ff)
		else $error("frame not ended at maximum size");
	a_remain_dec: assert property (
		state_ff == sdfp_pkg::ST_UPD_COUNT && !xfer_load |=>
		remain_ff[$past(port_ff)] ==
		$past(remain_ff[port_ff]) - CW'($past(fbytes_ff)) && bc_valid_ff)
		else $error("remaining count not lowered by frame size");
	a_sync_first: assert property (
		state_ff == sdfp_pkg::ST_WAIT && link_done && link_sync_esc |=>
		exit_valid_ff && exit_code_ff == sdfp_pkg::EXIT_SYNC_ESCAPE)
		else $error("sync escape not handled first");
	a_pend_chain: assert property (
		state_ff == sdfp_pkg::ST_UPD_COUNT && frame_irq_ff |=>
		state_ff == sdfp_pkg::ST_DESC_SET_INTR ##1
		status_ff[sdfp_pkg::ST_DESC_BIT] && !pend_ff[$past(port_ff, 2)])
		else $error("descriptor interrupt chain broken");
	a_desc_enable_gate: assert property (
		state_ff == sdfp_pkg::ST_DESC_SET_INTR &&
		!mask_ff[sdfp_pkg::ST_DESC_BIT] |=> state_ff == sdfp_pkg::ST_IDLE &&
		exit_code_ff == after_code($past(pio_ff[port_ff]), $past(sw_en)))
		else $error("interrupt enable off but chain went on");
	a_gpend_set: assert property (
		state_ff == sdfp_pkg::ST_DESC_SET_GLOBAL |=>
		gpend_ff ##1 (irq_ff == $past(gie)))
		else $error("global port bit or interrupt wrong");
	a_irq_hold: assert property (
		irq_ff && gie && !(wr_lane0 && (wb_adr_i == sdfp_pkg::GSTAT_OFS ||
		wb_adr_i == sdfp_pkg::STATUS_OFS || wb_adr_i == sdfp_pkg::CTRL_OFS ||
		wb_adr_i == sdfp_pkg::MASK_OFS)) |=> irq_ff)
		else $error("interrupt dropped without software clear");
	a_rx_entry: assert property (
		state_ff == sdfp_pkg::ST_IDLE && !tx_start && rx_fis |=>
		port_ff == $past(rx_port) && !pend_ff[port_ff] ##1 exit_valid_ff &&
		exit_code_ff == ($past(port_outstanding[port_ff]) ?
		sdfp_pkg::EXIT_RX_RECEIVE : sdfp_pkg::EXIT_INVALID_PORT))
		else $error("receive entry port check wrong");
	a_ack_pulse: assert property (
		wb_cyc_i && wb_stb_i && !ack_ff |=> ack_ff ##1 !ack_ff)
		else $error("ack not a single cycle");

	c_good_frame: cover property (
		state_ff == sdfp_pkg::ST_UPD_COUNT ##1 state_ff == sdfp_pkg::ST_IDLE);
	c_desc_irq: cover property (state_ff == sdfp_pkg::ST_DESC_GEN_INTR);
	c_dmat_mid: cover property (state_ff == sdfp_pkg::ST_XMIT && link_dmat);
	c_invalid: cover property (
		exit_valid_ff && exit_code_ff == sdfp_pkg::EXIT_INVALID_PORT);
endmodule : sdfp_port_fsm
`default_nettype wire

// *** sdfp_pkg.sv ***
/*
 * constants, offsets and types shared by the data frame port state machine.
 * assumes a 32-bit classic wishbone register bus and a 100 MHz clock.
 */
`default_nettype none
package sdfp_pkg;
	// register byte addresses
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] MASK_OFS = 8'h08;
	localparam logic [7:0] GSTAT_OFS = 8'h0c;
	localparam logic [7:0] PORT_OFS = 8'h10;
	localparam logic [7:0] REMAIN_OFS = 8'h14;
	// control register fields
	localparam int CTRL_SWITCH_BIT = 0;
	localparam int CTRL_GIE_BIT = 1;
	// status and mask register fields (same layout)
	localparam int ST_DESC_BIT = 0;
	localparam int ST_SYNC_BIT = 1;
	localparam int ST_NONFATAL_BIT = 2;
	localparam int ST_FATAL_BIT = 3;
	localparam int ST_BADPORT_BIT = 4;
	localparam int ST_W = 5;
	localparam logic [ST_W-1:0] ST_RESET = 5'h00;
	localparam logic [ST_W-1:0] MASK_RESET = 5'h00;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// frame sizing
	localparam int FRAME_BW = 14;
	localparam logic [FRAME_BW-1:0] FRAME_MAX_BYTES = 14'h2000;
	localparam logic [FRAME_BW-1:0] DWORD_BYTES = 14'h0004;
	// where the state machine hands control on
	localparam logic [2:0] EXIT_PORT_IDLE = 3'h0;
	localparam logic [2:0] EXIT_SWITCH_IDLE = 3'h1;
	localparam logic [2:0] EXIT_PIO_UPDATE = 3'h2;
	localparam logic [2:0] EXIT_RX_RECEIVE = 3'h3;
	localparam logic [2:0] EXIT_SYNC_ESCAPE = 3'h4;
	localparam logic [2:0] EXIT_NONFATAL = 3'h5;
	localparam logic [2:0] EXIT_FATAL = 3'h6;
	localparam logic [2:0] EXIT_INVALID_PORT = 3'h7;
	typedef enum logic [2:0] {
		ST_IDLE, ST_XMIT, ST_WAIT, ST_UPD_COUNT,
		ST_DESC_SET_INTR, ST_DESC_SET_GLOBAL, ST_DESC_GEN_INTR, ST_RX_ENTRY
	} sdfp_state_t;
endpackage : sdfp_pkg
`default_nettype wire

// *** sdfp_link_model.sv ***
/*
 * device-side link model for the data frame port bench.
 * assumes the bench sets the outcome before the frame's last dword.
 */
`default_nettype none
module sdfp_link_model (
	input wire logic clock, // bench clock
	input wire logic srst, // sync reset, high
	input wire logic link_valid, // dword offered
	input wire logic link_last, // dword ends the frame
	input wire logic slow, // take only every other cycle
	input wire logic [1:0] outcome, // 0 ok, 1 error, 2 escape, 3 lost
	output logic link_ready, // dword taken
	output logic link_done, // outcome pulse
	output logic link_rok, // frame accepted
	output logic link_rerr, // frame refused
	output logic link_sync_esc, // frame aborted
	output logic link_dmat // pause request
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_ff;
	always_ff @(posedge clock) begin
		if (srst) begin
			link_ready <= 1'h0;
			link_done <= 1'h0;
			wait_ff <= 2'h0;
			link_dmat <= 1'h0;
		end else begin
			link_ready <= slow ? ~link_ready : 1'h1;
			// a pause request during the frame must change nothing
			link_dmat <= slow & link_valid;
			link_done <= (wait_ff == 2'h1);
			if (link_valid && link_ready && link_last) begin
				wait_ff <= 2'h2;
			end else if (wait_ff != 2'h0) begin
				wait_ff <= wait_ff - 2'h1;
			end
		end
	end
	// outcome flags only carry meaning with the done pulse
	assign link_rok = link_done && outcome == 2'h0;
	assign link_rerr = link_done && outcome == 2'h1;
	assign link_sync_esc = link_done && outcome == 2'h2;
endmodule : sdfp_link_model
`default_nettype wire

// *** sdfp_port_fsm_bench.sv ***
/*
 * self-checking bench for the data frame port state machine.
 * assumes the package, the design and the link model are compiled first.
 */
`default_nettype none
module sdfp_port_fsm_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'h0;
	logic srst = 1'h1;
	logic cyc = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, irq, mem_ready, link_valid, link_last, link_ready;
	logic link_done, link_rok, link_rerr, link_sync_esc, link_dmat;
	logic byte_count_valid, exit_valid;
	logic [31:0] link_data;
	logic [13:0] byte_count_add;
	logic [2:0] exit_code;
	logic [3:0] current_port;
	logic xfer_load = 1'h0;
	logic xfer_pio = 1'h0;
	logic tx_start = 1'h0;
	logic rx_fis = 1'h0;
	logic slow = 1'h0;
	logic [3:0] xfer_port = 4'h0;
	logic [3:0] tx_port = 4'h0;
	logic [3:0] rx_port = 4'h0;
	logic [31:0] xfer_count = 32'h0;
	logic [1:0] outcome = 2'h0;
	logic mem_valid = 1'h0;
	logic mem_table_end = 1'h0;
	logic mem_entry_end = 1'h0;
	logic mem_entry_irq = 1'h0;
	logic entry_irq = 1'h1;
	logic [31:0] mem_data = 32'h0;
	logic [15:0] port_outstanding = 16'h0;
	logic [31:0] exp_data[$];
	logic [13:0] exp_bc[$];
	logic [2:0] exp_ex[$];
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;

	always #5 clock = ~clock;

	sdfp_port_fsm dut_u (.clock(clock), .srst(srst), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
		.xfer_load(xfer_load), .xfer_port(xfer_port), .xfer_count(xfer_count),
		.xfer_pio(xfer_pio), .tx_start(tx_start), .tx_port(tx_port),
		.mem_valid(mem_valid), .mem_data(mem_data),
		.mem_table_end(mem_table_end), .mem_entry_end(mem_entry_end),
		.mem_entry_irq(mem_entry_irq), .mem_ready(mem_ready),
		.link_valid(link_valid), .link_data(link_data), .link_last(link_last),
		.link_ready(link_ready), .link_done(link_done), .link_rok(link_rok),
		.link_rerr(link_rerr), .link_sync_esc(link_sync_esc),
		.link_dmat(link_dmat), .rx_fis(rx_fis), .rx_port(rx_port),
		.port_outstanding(port_outstanding),
		.byte_count_valid(byte_count_valid), .byte_count_add(byte_count_add),
		.exit_valid(exit_valid), .exit_code(exit_code),
		.current_port(current_port));

	sdfp_link_model link_u (.clock(clock), .srst(srst),
		.link_valid(link_valid), .link_last(link_last), .slow(slow),
		.outcome(outcome), .link_ready(link_ready), .link_done(link_done),
		.link_rok(link_rok), .link_rerr(link_rerr),
		.link_sync_esc(link_sync_esc), .link_dmat(link_dmat));

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// one classic cycle; ack is awaited, never assumed
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clock);
		while (wb_ack_o !== 1'h1) @(posedge clock);
		rdat = wb_dat_o;
		cyc <= 1'h0;
		@(posedge clock);
	endtask : bus

	task automatic rd(logic [7:0] a, logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk("register", e, rdat);
	endtask : rd

	task automatic settle();
		for (int i = 0; i < 200 && exp_ex.size() != 0; i++) @(posedge clock);
	endtask : settle

	// the last dword ends an entry; its interrupt bit follows entry_irq
	task automatic tx(logic [3:0] p, logic [31:0] cnt, logic pio, int ndw,
		logic tend, logic [1:0] oc, logic [2:0] ex);
		logic [31:0] d;
		xfer_load <= 1'h1;
		xfer_port <= p;
		xfer_count <= cnt;
		xfer_pio <= pio;
		@(posedge clock);
		xfer_load <= 1'h0;
		outcome <= oc;
		tx_start <= 1'h1;
		tx_port <= p;
		if (oc == 2'h0) exp_bc.push_back(14'(ndw * 4));
		exp_ex.push_back(ex);
		@(posedge clock);
		tx_start <= 1'h0;
		for (int i = 0; i < ndw; i++) begin
			d = $urandom;
			mem_valid <= 1'h1;
			mem_data <= d;
			mem_table_end <= tend && i == ndw - 1;
			mem_entry_end <= i == ndw - 1;
			mem_entry_irq <= entry_irq && i == ndw - 1;
			exp_data.push_back(d);
			@(posedge clock);
			while (mem_ready !== 1'h1) @(posedge clock);
		end
		mem_valid <= 1'h0;
		settle();
	endtask : tx

	task automatic rx(logic [3:0] p, logic [2:0] ex);
		rx_fis <= 1'h1;
		rx_port <= p;
		exp_ex.push_back(ex);
		@(posedge clock);
		rx_fis <= 1'h0;
		settle();
	endtask : rx

	always @(posedge clock) begin
		cycles++;
		if (link_valid === 1'h1 && link_ready === 1'h1)
			chk("link_data", exp_data.pop_front(), link_data);
		if (byte_count_valid === 1'h1)
			chk("byte_count", exp_bc.pop_front(), byte_count_add);
		if (exit_valid === 1'h1)
			chk("exit_code", exp_ex.pop_front(), exit_code);
		if (cycles == 30000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	initial begin
		logic [1:0] oc[4] = '{2'h2, 2'h1, 2'h1, 2'h3};
		logic [2:0] ex[4] = '{3'h4, 3'h5, 3'h6, 3'h6};
		void'($urandom(21));
		repeat (4) @(posedge clock);
		srst <= 1'h0;
		@(posedge clock);
		rd(sdfp_pkg::CTRL_OFS, 32'h0);
		rd(sdfp_pkg::STATUS_OFS, 32'h0);
		rd(sdfp_pkg::MASK_OFS, 32'h0);
		rd(sdfp_pkg::GSTAT_OFS, 32'h0);
		rd(8'h18, 32'h0);
		bus(1'h1, sdfp_pkg::CTRL_OFS, 32'h3);
		bus(1'h1, sdfp_pkg::MASK_OFS, 32'h1);
		tx(4'h2, 32'h8, 1'h0, 2, 1'h0, 2'h0, sdfp_pkg::EXIT_SWITCH_IDLE);
		repeat (6) @(posedge clock);
		chk("irq", 32'h1, irq);
		rd(sdfp_pkg::STATUS_OFS, 32'h1);
		rd(sdfp_pkg::GSTAT_OFS, 32'h1);
		rd(sdfp_pkg::REMAIN_OFS, 32'h0);
		bus(1'h1, sdfp_pkg::GSTAT_OFS, 32'h1);
		chk("irq", 32'h0, irq);
		bus(1'h1, sdfp_pkg::MASK_OFS, 32'h0);
		bus(1'h1, sdfp_pkg::CTRL_OFS, 32'h0);
		tx(4'h4, 32'h40, 1'h1, 3, 1'h1, 2'h0, sdfp_pkg::EXIT_PIO_UPDATE);
		rd(sdfp_pkg::GSTAT_OFS, 32'h0);
		rd(sdfp_pkg::REMAIN_OFS, 32'h34);
		slow <= 1'h1;
		entry_irq <= 1'h0;
		tx(4'h5, 32'h2328, 1'h0, 2048, 1'h0, 2'h0, 3'h0);
		slow <= 1'h0;
		entry_irq <= 1'h1;
		rd(sdfp_pkg::REMAIN_OFS, 32'h328);
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, sdfp_pkg::CTRL_OFS, {31'h0, i == 1});
			tx(4'h6, 32'h10, 1'h0, 4, 1'h0, oc[i], ex[i]);
		end
		rd(sdfp_pkg::STATUS_OFS, 32'hf);
		bus(1'h1, sdfp_pkg::STATUS_OFS, 32'h1f);
		port_outstanding <= 16'h0008;
		rx(4'h3, sdfp_pkg::EXIT_RX_RECEIVE);
		chk("current_port", 32'h3, current_port);
		rx(4'h5, sdfp_pkg::EXIT_INVALID_PORT);
		rd(sdfp_pkg::PORT_OFS, 32'h5);
		rd(sdfp_pkg::REMAIN_OFS, 32'h328);
		rd(sdfp_pkg::STATUS_OFS, 32'h10);
		chk("left_over", 32'h0,
			exp_ex.size() + exp_bc.size() + exp_data.size());
		tally_and_finish();
	end
endmodule : sdfp_port_fsm_bench
`default_nettype wire
